// file: rtl/cssq_cycle_table.sv
// bus cycle table: address selector and write flag per cycle
`timescale 1ns/1ps
`default_nettype none
`include "cssq_defines.svh"
module cssq_cycle_table import cssq_pkg::*; (
	cssq_step_if.tab step, // current state and cycle number
	input wire logic [15:0] pc, // opcode address
	input wire logic [15:0] sp, // stack pointer at start
	output logic [15:0] addr, // address for this cycle
	output logic rd_wr, // 1 read, 0 write
	output logic [2:0] src // byte source selector for writes
);
	// stack offset below/above sp by small amounts
	function automatic logic [15:0] sp_off(input logic [15:0] s,
		input logic [3:0] k, input logic up);
		sp_off = up ? s + {12'h000, k} : s - {12'h000, k};
	endfunction
	wire logic in_wait = step.state == 4'(CSSQ_WAIT);
	wire logic in_mul = step.state == 4'(CSSQ_MUL);
	wire logic in_rti = step.state == 4'(CSSQ_RTI);
	wire logic [3:0] wk = step.cyc - 4'h3;
	wire logic [3:0] rk = step.cyc - 4'h3;
	// address per cycle; cycles 1 and 2 are fetch and ignored operand
	assign addr = (step.cyc == 4'h1) ? pc :
		(step.cyc == 4'h2) ? pc + 16'h0001 :
		in_wait ? sp_off(sp, wk, 1'b0) :
		in_mul ? `CSSQ_IDLE_ADDR :
		in_rti ? sp_off(sp, rk, 1'b1) :
		pc;
	// only the push cycles write
	assign rd_wr = ~(in_wait && step.cyc >= 4'h3);
	assign src = wk[2:0];
endmodule // cssq_cycle_table
`default_nettype wire

// file: rtl/cssq_defines.svh
// constants for the stack and bus cycle sequencer
`ifndef CSSQ_DEFINES_SVH
`define CSSQ_DEFINES_SVH
`define CSSQ_IDLE_ADDR 16'hFFFF
`define CSSQ_MUL_CYCLES 4'hA
`define CSSQ_RTI_CYCLES 4'hA
`define CSSQ_WAI_LAST 4'h9
`define CSSQ_FRAME_BYTES 16'h0007
`endif

// file: rtl/cssq_pkg.sv
// types for the stack and bus cycle sequencer
package cssq_pkg;
	typedef enum logic [3:0] {
		CSSQ_IDLE = 4'h1,
		CSSQ_WAIT = 4'h2,
		CSSQ_MUL = 4'h4,
		CSSQ_RTI = 4'h8
	} cssq_state_t;
	typedef enum logic [1:0] {
		CSSQ_OP_WAIT = 2'h0,
		CSSQ_OP_MUL = 2'h1,
		CSSQ_OP_RTI = 2'h2
	} cssq_op_t;
endpackage

// file: rtl/cssq_sequencer.sv
// cycle sequencer for wait, multiply and return-from-interrupt
// Function
// - wait cycles 3,4 write return low at sp, high at sp-1
// - wait cycles 5,6 write index low at sp-2, high at sp-3
// - wait cycle 7 writes A at sp-4, cycle 8 writes B at sp-5
// - wait cycle 9 writes condition codes at sp-6
// - multiply takes 10 read cycles, idle cycles address FFFF
// - return takes 10 reads, last reads return low at sp+7
// - return pulls index high byte then low byte from next address
// - return pulls B then A from the next location
// - return reads condition codes first at sp+1 after dummy reads
`timescale 1ns/1ps
`default_nettype none
`include "cssq_defines.svh"
module cssq_sequencer import cssq_pkg::*; (
	input wire logic clk_sys, // 20 MHz machine clock
	input wire logic rst, // synchronous reset, active high
	input wire logic start, // begin an instruction, one-cycle pulse
	input wire logic [1:0] op, // which instruction
	input wire logic [15:0] pc, // opcode address
	input wire logic [15:0] sp_in, // stack pointer at start
	input wire logic [15:0] ret_addr, // return address to save
	input wire logic [15:0] idx, // index register
	input wire logic [7:0] acc_a, // accumulator a
	input wire logic [7:0] acc_b, // accumulator b
	input wire logic [7:0] ccr, // condition codes
	input wire logic [7:0] din, // read data from bus
	output logic busy, // sequence in progress
	output logic [15:0] addr, // bus address
	output logic rd_wr, // 1 read, 0 write
	output logic [7:0] dout, // write data
	output logic done, // last cycle pulse
	output logic [15:0] sp_out, // stack pointer after sequence
	output logic [7:0] ccr_out, // pulled condition codes
	output logic [7:0] a_out, // pulled accumulator a
	output logic [7:0] b_out, // pulled accumulator b
	output logic [15:0] idx_out, // pulled index register
	output logic [15:0] pc_out // pulled return address
);
	cssq_step_if step();
	cssq_state_t state_reg, state_next;
	logic [3:0] cyc_reg, cyc_next;
	logic [15:0] sp_reg;
	logic [15:0] a_w;
	logic rw_w;
	logic [7:0] wbyte;
	wire logic [3:0] last = (state_reg == CSSQ_WAIT) ? `CSSQ_WAI_LAST :
		(state_reg == CSSQ_MUL) ? `CSSQ_MUL_CYCLES : `CSSQ_RTI_CYCLES;
	wire logic at_end = (state_reg != CSSQ_IDLE) && (cyc_reg == last);
	assign step.state = state_reg;
	assign step.cyc = cyc_reg;
	cssq_cycle_table u_tab (
		.step(step),
		.pc(pc),
		.sp(sp_reg),
		.addr(a_w),
		.rd_wr(rw_w),
		.src()
	);
	// next state; starts are ignored while busy
	always_comb begin
		state_next = state_reg;
		cyc_next = cyc_reg;
		case (state_reg)
			CSSQ_IDLE: begin
				if (start) begin
					cyc_next = 4'h1;
					case (op)
						2'(CSSQ_OP_WAIT): state_next = CSSQ_WAIT;
						2'(CSSQ_OP_MUL): state_next = CSSQ_MUL;
						default: state_next = CSSQ_RTI;
					endcase
				end
			end
			CSSQ_WAIT, CSSQ_MUL, CSSQ_RTI: begin
				if (at_end) begin
					state_next = CSSQ_IDLE;
					cyc_next = 4'h0;
				end else begin
					cyc_next = cyc_reg + 4'h1;
				end
			end
			default: begin
				state_next = CSSQ_IDLE;
				cyc_next = 4'h0;
			end
		endcase
	end
	// push slot of the coming cycle: a registered dout must lead by one
	wire logic [3:0] k_nx = cyc_next - 4'h3;
	wire logic [2:0] src_nx = k_nx[2:0];
	// push byte order: ret lo, ret hi, x lo, x hi, a, b, ccr
	assign wbyte = (src_nx == 3'h0) ? ret_addr[7:0] :
		(src_nx == 3'h1) ? ret_addr[15:8] :
		(src_nx == 3'h2) ? idx[7:0] :
		(src_nx == 3'h3) ? idx[15:8] :
		(src_nx == 3'h4) ? acc_a :
		(src_nx == 3'h5) ? acc_b : ccr;
	assign busy = state_reg != CSSQ_IDLE;
	assign done = at_end;
	// bus outputs registered only in spirit of table; address is decoded
	assign addr = busy ? a_w : `CSSQ_IDLE_ADDR;
	assign rd_wr = busy ? rw_w : 1'b1;
	wire logic rti_cyc = state_reg == CSSQ_RTI;
	// sequencer state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= CSSQ_IDLE;
			cyc_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			cyc_reg <= cyc_next;
		end
	end
	// latch sp at start; final sp after return is start + 7
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp_reg <= 16'h0000;
			sp_out <= 16'h0000;
		end else begin
			if (start && !busy)
				sp_reg <= sp_in;
			if (at_end && rti_cyc)
				sp_out <= sp_reg + `CSSQ_FRAME_BYTES;
			else if (at_end && state_reg == CSSQ_WAIT)
				sp_out <= sp_reg - `CSSQ_FRAME_BYTES;
		end
	end
	// dout loads the coming cycle's byte, so it stands in its write cycle
	always_ff @(posedge clk_sys) begin
		if (rst)
			dout <= 8'h00;
		else
			dout <= wbyte;
	end
	// pulled bytes: ccr, b, a, x hi, x lo, pc hi, pc lo at cycles 4..10
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ccr_out <= 8'h00;
			a_out <= 8'h00;
			b_out <= 8'h00;
			idx_out <= 16'h0000;
			pc_out <= 16'h0000;
		end else if (rti_cyc) begin
			case (cyc_reg)
				4'h4: ccr_out <= din;
				4'h5: b_out <= din;
				4'h6: a_out <= din;
				4'h7: idx_out[15:8] <= din;
				4'h8: idx_out[7:0] <= din;
				4'h9: pc_out[15:8] <= din;
				4'hA: pc_out[7:0] <= din;
				default: ;
			endcase
		end
	end
endmodule // cssq_sequencer
`default_nettype wire

// file: rtl/cssq_step_if.sv
// cycle step carrier between sequencer and bus-cycle table
`timescale 1ns/1ps
`default_nettype none
interface cssq_step_if;
	logic [3:0] state;
	logic [3:0] cyc;
	modport seq (output state, output cyc);
	modport tab (input state, input cyc);
endinterface
`default_nettype wire

// file: testbench/cssq_chk.sv
// assertions for the stack and bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module cssq_chk (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic start, // begin
	input wire logic [1:0] op, // op
	input wire logic [15:0] pc, // opcode address
	input wire logic [15:0] sp_in, // stack in
	input wire logic busy, // running
	input wire logic [15:0] addr, // address
	input wire logic rd_wr, // 1 read
	input wire logic done, // last
	input wire logic [15:0] sp_out // stack out
);
	logic [3:0] c;
	logic [1:0] o;
	logic [15:0] s;
	wire logic [15:0] wa = s + 16'h3 - {12'h0, c};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// cycle number of the running sequence, zero while idle
	always_ff @(posedge clk_sys) begin
		if (rst) c <= 4'h0;
		else if (start && !busy) c <= 4'h1;
		else if (c != 4'h0 && !done) c <= c + 4'h1;
		else c <= 4'h0;
	end
	// op and base kept unreset: c stays zero until they are valid
	always_ff @(posedge clk_sys) if (start && !busy) begin
		o <= op;
		s <= sp_in;
	end
	a_wait_push:
	assert property (o==2'h0 && c>4'h2 |-> addr==wa && !rd_wr) else $error("push");
	a_wait_end:
	assert property (o==2'h0 && c==4'h9 |-> done) else $error("wait end");
	a_mul_idle:
	assert property (o==2'h1 && c>4'h2 |-> addr==16'hFFFF && rd_wr) else $error("mul");
	a_mul_len:
	assert property (o==2'h1 && c==4'h2 |-> !done[*8] ##1 done) else $error("mul");
	a_rti_last:
	assert property (o[1] && c==4'hA |-> done && rd_wr && addr==s+16'h7) else $error("rl");
	a_rti_ccr:
	assert property (o[1] && c==4'h4 |-> rd_wr && addr==s+16'h1) else $error("rc");
	a_rti_pulls:
	assert property (o[1] && c==4'h5 |-> addr==s+16'h2 ##1 addr==s+16'h3
		##1 addr==s+16'h4 ##1 addr==s+16'h5) else $error("pull");
	a_rti_sp:
	assert property (o[1] && done |=> sp_out==s+16'h7) else $error("sp");
	a_wait_len:
	assert property (o==2'h0 && c==4'h2 |-> !done[*7] ##1 done)
		else $error("wait length");
	a_rti_len:
	assert property (o[1] && c==4'h2 |-> !done[*8] ##1 done)
		else $error("return length");
	a_rti_reads:
	assert property (o[1] && busy |-> rd_wr) else $error("return write");
	a_rti_dummy:
	assert property (o[1] && c==4'h3 |-> rd_wr && addr==s)
		else $error("return dummy");
	a_mul_fetch:
	assert property (o==2'h1 && c==4'h1 |-> addr==pc && rd_wr
		##1 addr==pc+16'h1 && rd_wr) else $error("mul fetch");
	a_busy_span:
	assert property (busy == (c != 4'h0)) else $error("busy span");
endmodule // cssq_chk
bind cssq_sequencer cssq_chk cssq_chk_i (.clk_sys, .rst, .start, .op, .pc,
	.sp_in, .busy, .addr, .rd_wr, .done, .sp_out);
`default_nettype wire

// file: testbench/cssq_mem.sv
// stack and program memory model on the sequencer bus
`timescale 1ns/1ps
`default_nettype none
module cssq_mem (
	input wire logic clk_sys, // clock
	input wire logic [15:0] addr, // address
	input wire logic rd_wr, // 1 read
	input wire logic busy, // cycle valid
	input wire logic [7:0] dout, // write byte of this cycle
	output logic [7:0] din // read byte
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] junk = 8'h5A;
	// a write commits at the edge that ends its cycle
	always @(posedge clk_sys) begin
		if (busy && !rd_wr) mem[addr] = dout;
		junk <= ~junk;
	end
	// idle or unwritten reads see a toggling pattern, never held data
	always @* din = (busy && rd_wr && mem.exists(addr)) ? mem[addr] : junk;
endmodule // cssq_mem
`default_nettype wire

// file: testbench/test_cssq_sequencer.sv
// self-checking bench for the stack and bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module test_cssq_sequencer;
	logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, busy, rd_wr, done;
	logic fin = 1'b0;
	logic [1:0] op = 2'h0;
	logic [15:0] pc = 16'h0, sp_in = 16'h0, ret_addr = 16'h0, idx = 16'h0, s;
	logic [15:0] addr, sp_out, idx_out, pc_out;
	logic [7:0] acc_a = 8'h0, acc_b = 8'h0, ccr = 8'h0, din, dout;
	logic [7:0] ccr_out, a_out, b_out;
	logic [71:0] eq[$], mq[$];
	int miscompares = 0, tests_run = 0, i, seed = 32'h6b5fff20;
	cssq_sequencer cssq_sequencer_i (.clk_sys, .rst, .start, .op, .pc, .sp_in,
		.ret_addr, .idx, .acc_a, .acc_b, .ccr, .din, .busy, .addr, .rd_wr,
		.dout, .done, .sp_out, .ccr_out, .a_out, .b_out, .idx_out, .pc_out);
	cssq_mem cssq_mem_i (.clk_sys, .addr, .rd_wr, .busy, .dout, .din);
	initial forever #25 clk_sys = ~clk_sys;
	task tally_and_finish;
		if (eq.size() != 0) begin
			miscompares++;
			$display("[FAIL] %0t %0d results never came", $time, eq.size());
		end
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cmp(input logic [71:0] g, e, m);
		tests_run++;
		if ((g & m) !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// one instruction; poke retries start mid-run, which must be ignored
	task run(input logic [1:0] o, input logic [15:0] b, input logic [71:0] e, m,
		input logic poke);
		@(negedge clk_sys);
		{start, op, sp_in, pc} = {1'b1, o, b, 16'($random(seed))};
		eq.push_back(e & m);
		mq.push_back(m);
		@(negedge clk_sys);
		start = 1'b0;
		if (poke) begin
			@(negedge clk_sys);
			start = 1'b1;
			@(negedge clk_sys);
			start = 1'b0;
		end
		repeat (11) @(negedge clk_sys);
		$display("op %0d finished", o);
	endtask
	// outputs are registered, so judge them one cycle after done
	always @(negedge clk_sys) begin
		if (fin && eq.size() == 0) begin
			miscompares++;
			$display("[FAIL] %0t extra done", $time);
		end else if (fin)
			cmp({sp_out, ccr_out, b_out, a_out, idx_out, pc_out},
				eq.pop_front(), mq.pop_front());
		fin = (done === 1'b1);
	end
	// wait pushes a frame, return pulls it back; s=3 wraps the stack
	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		for (i = 0; i < 4; i++) begin
			s = (i == 0) ? 16'h3 : 16'($random(seed));
			{ret_addr, idx, acc_a, acc_b, ccr} =
				56'({$random(seed), $random(seed)});
			run(2'h0, s, {s - 16'h7, 56'h0}, {16'hFFFF, 56'h0}, 1'b0);
			run({1'b1, i[0]}, s - 16'h7, {s, ccr, acc_b, acc_a, idx, ret_addr},
				{72{1'b1}}, 1'b0);
			run(2'h1, s, {s, ccr, acc_b, acc_a, idx, ret_addr},
				{72{1'b1}}, i == 1);
		end
		tally_and_finish;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		miscompares++;
		$display("[FAIL] %0t timeout", $time);
		tally_and_finish;
	end
endmodule // test_cssq_sequencer
`default_nettype wire
